// >>> slpr_pkg.sv
// Package of offsets, field layouts and reset values for the serial link parameter registers
package slpr_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 7;

  // Register offsets
  localparam logic [15:0] OFS_LANE_CNT   = 16'h058b;
  localparam logic [15:0] OFS_OCTETS     = 16'h058c;
  localparam logic [15:0] OFS_FRAMES_MF  = 16'h058d;
  localparam logic [15:0] OFS_CONVERTERS = 16'h058e;
  localparam logic [15:0] OFS_CS_RES     = 16'h058f;
  localparam logic [15:0] OFS_SUBCL_NP   = 16'h0590;
  localparam logic [15:0] OFS_SAMPLES    = 16'h0591;

  // One-hot select positions
  localparam int unsigned SEL_LANE_CNT   = 0;
  localparam int unsigned SEL_OCTETS     = 1;
  localparam int unsigned SEL_FRAMES_MF  = 2;
  localparam int unsigned SEL_CONVERTERS = 3;
  localparam int unsigned SEL_CS_RES     = 4;
  localparam int unsigned SEL_SUBCL_NP   = 5;
  localparam int unsigned SEL_SAMPLES    = 6;

  // Field positions
  localparam int unsigned SCR_BIT     = 7;
  localparam int unsigned LANES_MSB   = 4;
  localparam int unsigned K_MSB       = 4;
  localparam int unsigned CS_MSB      = 7;
  localparam int unsigned CS_LSB      = 6;
  localparam int unsigned N_MSB       = 4;
  localparam int unsigned NP_MSB      = 4;
  localparam int unsigned SUBCL_MSB   = 7;
  localparam int unsigned SUBCL_LSB   = 5;
  localparam int unsigned S_MSB       = 4;
  localparam int unsigned S_RSV_MSB   = 7;
  localparam int unsigned S_RSV_LSB   = 5;

  // Reset values
  localparam logic       SCR_RST     = 1'h1;
  localparam logic [4:0] LANES_RST   = 5'h01;
  localparam logic [7:0] OCTETS_RST  = 8'h01;
  localparam logic [4:0] K_RST       = 5'h1f;
  localparam logic [7:0] CONV_RST    = 8'h01;
  localparam logic [1:0] CS_RST      = 2'h0;
  localparam logic [4:0] N_RST       = 5'h0f;
  localparam logic [4:0] NP_RST      = 5'h0f;
  localparam logic [2:0] SUBCL_RST   = 3'h1;
  localparam logic [4:0] S_RST       = 5'h00;
  localparam logic [2:0] S_RSV_RST   = 3'h1;

  // Field codes
  localparam logic [4:0] LANES_ONE   = 5'h00;
  localparam logic [4:0] LANES_TWO   = 5'h01;
  localparam logic [7:0] CONV_ONE    = 8'h00;
  localparam logic [7:0] CONV_TWO    = 8'h01;
  localparam logic [7:0] CONV_FOUR   = 8'h03;
  localparam logic [1:0] CS_NONE     = 2'h0;
  localparam logic [1:0] CS_BIT0     = 2'h1;
  localparam logic [4:0] N_MIN_CODE  = 5'h06;
  localparam logic [4:0] N_MAX_CODE  = 5'h0f;
  localparam logic [4:0] NP_8_CODE   = 5'h07;
  localparam logic [4:0] NP_16_CODE  = 5'h0f;
  localparam int unsigned K_STEP     = 4;
  localparam int unsigned FK_DIV     = 4;

endpackage : slpr_pkg

// >>> slpr_dec_if.sv
// Interface carrying the register access address and the decoded register selects
`timescale 1ns/1ns
interface slpr_dec_if;
  logic [slpr_pkg::ADDR_W-1:0]   addr;
  logic [slpr_pkg::NUM_REGS-1:0] sel;
  logic                          hit;

  modport core (output addr, input sel, input hit);
  modport dec  (input addr, output sel, output hit);
endinterface : slpr_dec_if

// >>> slpr_addr_dec.sv
// Address decoder for the serial link parameter registers
`timescale 1ns/1ns
module slpr_addr_dec (
  slpr_dec_if.dec bus  // Address in, one-hot selects out
);

  function automatic logic [slpr_pkg::NUM_REGS-1:0] decode(input logic [slpr_pkg::ADDR_W-1:0] a);
    logic [slpr_pkg::NUM_REGS-1:0] s;
    s = '0;
    s[slpr_pkg::SEL_LANE_CNT]   = (a == slpr_pkg::OFS_LANE_CNT);
    s[slpr_pkg::SEL_OCTETS]     = (a == slpr_pkg::OFS_OCTETS);
    s[slpr_pkg::SEL_FRAMES_MF]  = (a == slpr_pkg::OFS_FRAMES_MF);
    s[slpr_pkg::SEL_CONVERTERS] = (a == slpr_pkg::OFS_CONVERTERS);
    s[slpr_pkg::SEL_CS_RES]     = (a == slpr_pkg::OFS_CS_RES);
    s[slpr_pkg::SEL_SUBCL_NP]   = (a == slpr_pkg::OFS_SUBCL_NP);
    s[slpr_pkg::SEL_SAMPLES]    = (a == slpr_pkg::OFS_SAMPLES);
    return s;
  endfunction : decode

  always_comb begin
    bus.sel = decode(bus.addr);
    bus.hit = |bus.sel;
  end

endmodule : slpr_addr_dec

// >>> slpr_regs.sv
// Serial link transmitter parameter register bank with registered read port and decoded link settings
`timescale 1ns/1ns
module slpr_regs (
  input  wire logic        mclk,            // Register port clock
  input  wire logic        resetn,          // Asynchronous reset, active low
  input  wire logic [15:0] reg_addr,        // Register address
  input  wire logic        reg_wr_en,       // Write strobe, one cycle
  input  wire logic        reg_rd_en,       // Read strobe, one cycle
  input  wire logic [7:0]  reg_wdata,       // Write data
  output logic      [7:0]  reg_rdata,       // Read data, valid with reg_rd_valid
  output logic             reg_rd_valid,    // Read answer pulse
  output logic             reg_addr_err,    // Pulse: access to unmapped address
  output logic             scramble_en,     // Transmit scrambler enable
  output logic      [1:0]  lane_count,      // Lanes per link
  output logic      [8:0]  frame_octets,    // Octets per frame
  output logic      [5:0]  mf_frames,       // Frames per multiframe
  output logic      [2:0]  converter_count, // Virtual converters per link
  output logic      [1:0]  control_bits,    // Control bits per sample
  output logic      [4:0]  resolution,      // Converter resolution in bits
  output logic      [4:0]  sample_bits,     // Bits per sample
  output logic      [5:0]  frame_samples,   // Samples per converter frame cycle
  output logic             cfg_valid        // Set when all writable fields hold supported codes
);

  localparam int unsigned DW = slpr_pkg::DATA_W;

  slpr_dec_if dec_bus ();

  slpr_addr_dec u_dec (
    .bus (dec_bus.dec)
  );

  assign dec_bus.addr = reg_addr;

  // Writable storage
  logic       scr_r;
  logic [4:0] k_m1_r;
  logic [1:0] cs_r;
  logic [4:0] n_m1_r;
  logic [4:0] np_r;

  // Fixed fields; kept as constants so writes can never reach them
  logic [4:0] lanes_code;
  logic [7:0] octets_m1;
  logic [7:0] conv_code;
  logic [4:0] s_m1;

  assign lanes_code = slpr_pkg::LANES_RST;
  assign octets_m1  = slpr_pkg::OCTETS_RST;
  assign conv_code  = slpr_pkg::CONV_RST;
  assign s_m1       = slpr_pkg::S_RST;

  logic wr_lane;
  logic wr_k;
  logic wr_csn;
  logic wr_np;

  assign wr_lane = reg_wr_en & dec_bus.sel[slpr_pkg::SEL_LANE_CNT];
  assign wr_k    = reg_wr_en & dec_bus.sel[slpr_pkg::SEL_FRAMES_MF];
  assign wr_csn  = reg_wr_en & dec_bus.sel[slpr_pkg::SEL_CS_RES];
  assign wr_np   = reg_wr_en & dec_bus.sel[slpr_pkg::SEL_SUBCL_NP];

  // Scrambler enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scr_r <= slpr_pkg::SCR_RST;
    end else if (wr_lane) begin
      scr_r <= reg_wdata[slpr_pkg::SCR_BIT];
    end
  end

  // Frames per multiframe; any code is stored, support is flagged separately
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      k_m1_r <= slpr_pkg::K_RST;
    end else if (wr_k) begin
      k_m1_r <= reg_wdata[slpr_pkg::K_MSB:0];
    end
  end

  // Control bits; shares its register with the resolution, bit 5 between them is fixed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cs_r <= slpr_pkg::CS_RST;
    end else if (wr_csn) begin
      cs_r <= reg_wdata[slpr_pkg::CS_MSB:slpr_pkg::CS_LSB];
    end
  end

  // Resolution; unsupported codes are kept and only clear cfg_valid
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n_m1_r <= slpr_pkg::N_RST;
    end else if (wr_csn) begin
      n_m1_r <= reg_wdata[slpr_pkg::N_MSB:0];
    end
  end

  // Bits per sample; the subclass bits above it are not writable here
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      np_r <= slpr_pkg::NP_RST;
    end else if (wr_np) begin
      np_r <= reg_wdata[slpr_pkg::NP_MSB:0];
    end
  end

  function automatic logic [DW-1:0] read_mux(input logic [slpr_pkg::NUM_REGS-1:0] sel,
                                             input logic scr, input logic [4:0] k,
                                             input logic [1:0] cs, input logic [4:0] n,
                                             input logic [4:0] np);
    logic [DW-1:0] d;
    d = '0;
    if (sel[slpr_pkg::SEL_LANE_CNT]) begin
      d = {scr, 2'h0, slpr_pkg::LANES_RST};
    end
    if (sel[slpr_pkg::SEL_OCTETS]) begin
      d = slpr_pkg::OCTETS_RST;
    end
    if (sel[slpr_pkg::SEL_FRAMES_MF]) begin
      d = {3'h0, k};
    end
    if (sel[slpr_pkg::SEL_CONVERTERS]) begin
      d = slpr_pkg::CONV_RST;
    end
    if (sel[slpr_pkg::SEL_CS_RES]) begin
      d = {cs, 1'h0, n};
    end
    if (sel[slpr_pkg::SEL_SUBCL_NP]) begin
      d = {slpr_pkg::SUBCL_RST, np};
    end
    if (sel[slpr_pkg::SEL_SAMPLES]) begin
      d = {slpr_pkg::S_RSV_RST, slpr_pkg::S_RST};
    end
    return d;
  endfunction : read_mux

  // Read answer one cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
    end
  end

  // Read data held until the next read; reserved bits give their reset values
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd_en) begin
      reg_rdata <= read_mux(dec_bus.sel, scr_r, k_m1_r, cs_r, n_m1_r, np_r);
    end
  end

  // Unmapped access: writes dropped, reads return zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_addr_err <= 1'b0;
    end else begin
      reg_addr_err <= (reg_rd_en | reg_wr_en) & ~dec_bus.hit;
    end
  end

  function automatic logic [2:0] conv_decode(input logic [7:0] code);
    logic [2:0] m;
    m = 3'h1;
    if (code == slpr_pkg::CONV_TWO) begin
      m = 3'h2;
    end
    if (code == slpr_pkg::CONV_FOUR) begin
      m = 3'h4;
    end
    return m;
  endfunction : conv_decode

  // Stored codes hold a count minus one; callers other than the octet count cut the sum to their field width
  function automatic logic [8:0] count_of(input logic [7:0] code);
    return {1'b0, code} + 9'h001;
  endfunction : count_of

  logic [5:0]  k_count;
  logic [8:0]  f_count;
  logic [14:0] fk_prod;
  logic        k_ok;
  logic        fk_ok;
  logic        cs_ok;
  logic        n_ok;
  logic        np_ok;

  always_comb begin
    k_count = 6'(count_of({3'h0, k_m1_r}));
    f_count = count_of(octets_m1);
    fk_prod = 15'(f_count * k_count);
    k_ok    = (k_count[1:0] == 2'h0);
    fk_ok   = (fk_prod[1:0] == 2'h0);
    cs_ok   = (cs_r == slpr_pkg::CS_NONE) || (cs_r == slpr_pkg::CS_BIT0);
    n_ok    = (n_m1_r >= slpr_pkg::N_MIN_CODE) && (n_m1_r <= slpr_pkg::N_MAX_CODE);
    np_ok   = (np_r == slpr_pkg::NP_8_CODE) || (np_r == slpr_pkg::NP_16_CODE);
  end

  // Scrambler enable, registered so the transmitter sees a clean level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scramble_en <= slpr_pkg::SCR_RST;
    end else begin
      scramble_en <= scr_r;
    end
  end

  // Lanes per link as a count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lane_count <= 2'h2;
    end else begin
      lane_count <= (lanes_code == slpr_pkg::LANES_ONE) ? 2'h1 : 2'h2;
    end
  end

  // Octets per frame as a count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_octets <= 9'h002;
    end else begin
      frame_octets <= f_count;
    end
  end

  // Frames per multiframe as a count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mf_frames <= 6'h20;
    end else begin
      mf_frames <= k_count;
    end
  end

  // Virtual converters per link as a count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      converter_count <= 3'h1;
    end else begin
      converter_count <= conv_decode(conv_code);
    end
  end

  // Control bits per sample, passed on as stored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      control_bits <= 2'h0;
    end else begin
      control_bits <= cs_r;
    end
  end

  // Resolution in bits; code 31 wraps to zero because the output is five bits wide
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resolution <= 5'h10;
    end else begin
      resolution <= 5'(count_of({3'h0, n_m1_r}));
    end
  end

  // Bits per sample, same wrap as the resolution
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sample_bits <= 5'h10;
    end else begin
      sample_bits <= 5'(count_of({3'h0, np_r}));
    end
  end

  // Samples per converter frame cycle as a count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_samples <= 6'h01;
    end else begin
      frame_samples <= 6'(count_of({3'h0, s_m1}));
    end
  end

  // Low in reset so the receiver never starts on a half-loaded setting
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_valid <= 1'b0;
    end else begin
      cfg_valid <= k_ok & fk_ok & cs_ok & n_ok & np_ok;
    end
  end

endmodule : slpr_regs

// >>> slpr_rx_model.sv
// Receiver-side model that checks the multiframe length of the configured link
`timescale 1ns/1ns
module slpr_rx_model (
  input  wire logic [8:0]  frame_octets, // Octets per frame
  input  wire logic [5:0]  mf_frames,    // Frames per multiframe
  output logic      [14:0] mf_octets,    // Octets per multiframe
  output logic             aligned       // Multiframe is a whole number of 4-octet words
);
  assign mf_octets = 15'(frame_octets * mf_frames);
  assign aligned   = (mf_octets[1:0] == 2'h0);
endmodule : slpr_rx_model

// >>> slpr_regs_monitor.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module slpr_regs_monitor (
  input wire logic        mclk,            // Clock
  input wire logic        resetn,          // Reset, active low
  input wire logic [15:0] reg_addr,        // Address
  input wire logic        reg_wr_en,       // Write strobe
  input wire logic        reg_rd_en,       // Read strobe
  input wire logic [7:0]  reg_wdata,       // Write data
  input wire logic [7:0]  reg_rdata,       // Read data
  input wire logic        reg_rd_valid,    // Read answer
  input wire logic        reg_addr_err,    // Unmapped access
  input wire logic        scramble_en,     // Scrambler enable
  input wire logic [1:0]  lane_count,      // Lanes
  input wire logic [8:0]  frame_octets,    // Octets per frame
  input wire logic [5:0]  mf_frames,       // Frames per multiframe
  input wire logic [2:0]  converter_count, // Converters
  input wire logic [1:0]  control_bits,    // Control bits
  input wire logic [4:0]  resolution,      // Resolution
  input wire logic [4:0]  sample_bits,     // Bits per sample
  input wire logic [5:0]  frame_samples    // Samples per frame
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_rd_answer; reg_rd_en |=> reg_rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_scr; reg_wr_en && reg_addr == 16'h058b |-> ##2 scramble_en == $past(reg_wdata[7], 2); endproperty
  a_scr: assert property (p_scr) else $error("scrambler enable wrong");
  property p_fixed; lane_count == 2'h2 && frame_octets == 9'h002 && frame_samples == 6'h01; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed link value wrong");
  property p_conv; $past(resetn) |-> converter_count == 3'h2; endproperty
  a_conv: assert property (p_conv) else $error("converter count wrong");
  property p_k; reg_wr_en && reg_addr == 16'h058d |-> ##2 mf_frames == {1'b0, $past(reg_wdata[4:0], 2)} + 6'h01; endproperty
  a_k: assert property (p_k) else $error("frames per multiframe wrong");
  property p_cs; reg_wr_en && reg_addr == 16'h058f |-> ##2 control_bits == $past(reg_wdata[7:6], 2); endproperty
  a_cs: assert property (p_cs) else $error("control bits wrong");
  property p_res; reg_wr_en && reg_addr == 16'h058f |-> ##2 resolution == $past(reg_wdata[4:0], 2) + 5'h01; endproperty
  a_res: assert property (p_res) else $error("resolution wrong");
  property p_np; reg_wr_en && reg_addr == 16'h0590 |-> ##2 sample_bits == $past(reg_wdata[4:0], 2) + 5'h01; endproperty
  a_np: assert property (p_np) else $error("bits per sample wrong");
  property p_ro_read; reg_rd_en && reg_addr == 16'h058c |=> reg_rdata == 8'h01; endproperty
  a_ro_read: assert property (p_ro_read) else $error("octet register changed");
  c_unmapped: cover property (reg_rd_en ##1 reg_addr_err);
  c_k_write: cover property (reg_wr_en && reg_addr == 16'h058d);
  c_wr_rd: cover property (reg_wr_en ##1 reg_rd_en);
endmodule : slpr_regs_monitor
bind slpr_regs slpr_regs_monitor slpr_regs_monitor_i (.mclk, .resetn, .reg_addr, .reg_wr_en, .reg_rd_en,
  .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_addr_err, .scramble_en, .lane_count, .frame_octets, .mf_frames,
  .converter_count, .control_bits, .resolution, .sample_bits, .frame_samples);

// >>> tb_top.sv
// Testbench for the serial link parameter register bank
`timescale 1ns/1ns
module tb_top;
  logic        mclk, resetn, reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_err, scramble_en, cfg_valid, aligned;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  lane_count, control_bits;
  logic [8:0]  frame_octets;
  logic [5:0]  mf_frames, frame_samples;
  logic [2:0]  converter_count;
  logic [4:0]  resolution, sample_bits;
  int          n_fail, num_checks;

  slpr_regs slpr_regs_i (.mclk, .resetn, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .reg_addr_err, .scramble_en, .lane_count, .frame_octets, .mf_frames, .converter_count, .control_bits,
    .resolution, .sample_bits, .frame_samples, .cfg_valid);
  slpr_rx_model slpr_rx_model_i (.frame_octets, .mf_frames, .mf_octets(), .aligned);

  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // Read answer stands one cycle, so it is sampled just after the taking edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic err);
    @(posedge mclk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    #1;
    chk_val({1'b0, reg_rdata}, {1'b0, exp}, "read data");
    chk_val({8'h00, reg_rd_valid}, 9'h001, "read valid");
    chk_val({8'h00, reg_addr_err}, {8'h00, err}, "address error");
  endtask : rd

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {resetn, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rd(16'h058b, 8'h81, 1'b0);
    rd(16'h058c, 8'h01, 1'b0);
    rd(16'h058d, 8'h1f, 1'b0);
    rd(16'h058e, 8'h01, 1'b0);
    rd(16'h058f, 8'h0f, 1'b0);
    rd(16'h0590, 8'h2f, 1'b0);
    rd(16'h0591, 8'h20, 1'b0);
    chk_val({3'h0, mf_frames}, 9'h020, "frames");
    chk_val({7'h0, lane_count}, 9'h002, "lanes");
    chk_val(frame_octets, 9'h002, "octets");
    chk_val({3'h0, frame_samples}, 9'h001, "samples");
    chk_val({8'h00, cfg_valid}, 9'h001, "config valid");
    wr(16'h058b, 8'h7e);
    rd(16'h058b, 8'h01, 1'b0);
    chk_val({8'h00, scramble_en}, 9'h000, "scrambler");
    wr(16'h058c, 8'hff);
    wr(16'h058e, 8'hff);
    wr(16'h0591, 8'hff);
    rd(16'h058c, 8'h01, 1'b0);
    rd(16'h058e, 8'h01, 1'b0);
    rd(16'h0591, 8'h20, 1'b0);
    chk_val({6'h0, converter_count}, 9'h002, "converters");
    for (int k = 4; k <= 32; k += 4) begin
      wr(16'h058d, 8'(k - 1));
      rd(16'h058d, 8'(k - 1), 1'b0);
      chk_val({3'h0, mf_frames}, 9'(k), "frames");
      chk_val({8'h00, aligned}, 9'h001, "alignment");
      chk_val({8'h00, cfg_valid}, 9'h001, "config valid");
    end
    wr(16'h058d, 8'he3);
    rd(16'h058d, 8'h03, 1'b0);
    wr(16'h058f, 8'h66);
    rd(16'h058f, 8'h46, 1'b0);
    chk_val({7'h0, control_bits}, 9'h001, "control bits");
    chk_val({4'h0, resolution}, 9'h007, "resolution");
    wr(16'h058f, 8'h0f);
    rd(16'h058f, 8'h0f, 1'b0);
    chk_val({4'h0, resolution}, 9'h010, "resolution");
    wr(16'h0590, 8'he7);
    rd(16'h0590, 8'h27, 1'b0);
    chk_val({4'h0, sample_bits}, 9'h008, "sample bits");
    wr(16'h0590, 8'h0f);
    chk_val({4'h0, sample_bits}, 9'h008, "sample bits");
    rd(16'h0590, 8'h2f, 1'b0);
    chk_val({4'h0, sample_bits}, 9'h010, "sample bits");
    wr(16'h0590, 8'h08);
    rd(16'h0590, 8'h28, 1'b0);
    chk_val({4'h0, sample_bits}, 9'h009, "sample bits");
    chk_val({8'h00, cfg_valid}, 9'h000, "config valid");
    wr(16'h0590, 8'h0f);
    rd(16'h0590, 8'h2f, 1'b0);
    chk_val({8'h00, cfg_valid}, 9'h001, "config valid");
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_val({8'h00, scramble_en}, 9'h001, "scrambler in reset");
    chk_val({3'h0, mf_frames}, 9'h020, "frames in reset");
    chk_val({8'h00, cfg_valid}, 9'h000, "config valid in reset");
    chk_val({8'h00, reg_rd_valid}, 9'h000, "read valid in reset");
    resetn <= 1'b1;
    rd(16'h058b, 8'h81, 1'b0);
    rd(16'h058d, 8'h1f, 1'b0);
    chk_val({8'h00, cfg_valid}, 9'h001, "config valid after reset");
    wr(16'h0592, 8'hff);
    #1;
    chk_val({8'h00, reg_addr_err}, 9'h001, "write address error");
    rd(16'h0592, 8'h00, 1'b1);
    end_of_test();
  end
endmodule : tb_top
